// ### rtl/adcsq_csr.sv
module adcsq_csr
	import adcsq_pkg::*;
#(
	parameter int  SLOT_COUNT = 64,
	parameter bit  DUAL       = 1'b0
) (
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          rst,
	// Sequencer register port
	input  wire adcsq_req_t    seq_req,
	output logic [31:0]        seq_readdata,
	// Sample store register port
	input  wire adcsq_req_t    store_req,
	output logic [31:0]        store_readdata,
	// Converter side
	input  wire adcsq_result_t result,
	input  wire logic          cal_done,
	output logic               conv_run,
	output logic [2:0]         conv_mode,
	// Interrupt
	output logic               irq
);

	// ==========================================================
	// Elaboration checks
	// The slot index is six bits wide, so more than 64 cannot be served
	if (SLOT_COUNT < 1 || SLOT_COUNT > 64) begin : g_bad_count
		$error("SLOT_COUNT must lie in 1..64");
	end

	// Slot word formatting, upper and gap bits zero
	function automatic logic [31:0] slot_word(
		input logic [11:0] first_v,
		input logic [11:0] second_v
	);
		logic [31:0] w;
		w = 32'h0;
		w[FIRST_LSB +: SAMPLE_W] = first_v;
		if (DUAL)
			w[SECOND_LSB +: SAMPLE_W] = second_v;
		return w;
	endfunction : slot_word

	// ==========================================================
	// Sequencer
	adcsq_state_t state_reg, state_next;
	logic         run_reg, run_next;
	logic         stop_req_reg, stop_req_next;
	logic [2:0]   mode_reg, mode_next;
	logic [31:0]  seq_rd_reg, seq_rd_next;
	logic         seq_wr;
	logic         seq_done;

	assign seq_wr   = seq_req.write && seq_req.address[0] == SEQ_CMD_OFS;
	assign seq_done = result.valid && result.last;

	// Next state of the sequencer and its command register
	always_comb begin
		state_next    = state_reg;
		run_next      = run_reg;
		stop_req_next = stop_req_reg;
		mode_next     = mode_reg;
		seq_rd_next   = RDATA_RST;
		if (seq_wr) begin
			// Mode only accepted while stopped
			if (!run_reg)
				mode_next = seq_req.writedata[CMD_MODE_MSB:CMD_MODE_LSB];
			if (seq_req.writedata[CMD_RUN_BIT] && !run_reg) begin
				run_next      = 1'b1;
				stop_req_next = 1'b0;
			end else if (!seq_req.writedata[CMD_RUN_BIT] && run_reg)
				stop_req_next = 1'b1;
			else if (seq_req.writedata[CMD_RUN_BIT])
				stop_req_next = 1'b0;
		end
		unique case (state_reg)
			ADCSQ_IDLE: begin
				if (run_reg)
					state_next = (mode_reg == MODE_RECAL) ?
						ADCSQ_CAL : ADCSQ_CONV;
			end
			ADCSQ_CONV: begin
				// Stop only lands on a sequence boundary
				if (seq_done && (stop_req_reg || stop_req_next ||
						mode_reg == MODE_SINGLE)) begin
					state_next    = ADCSQ_IDLE;
					run_next      = 1'b0;
					stop_req_next = 1'b0;
				end
			end
			ADCSQ_CAL: begin
				// Recalibration always runs to completion
				if (cal_done) begin
					state_next    = ADCSQ_IDLE;
					run_next      = 1'b0;
					stop_req_next = 1'b0;
				end
			end
			// Unused state code falls back to idle
			default: state_next = ADCSQ_IDLE;
		endcase
		if (seq_req.read && seq_req.address[0] == SEQ_CMD_OFS) begin
			seq_rd_next[CMD_RUN_BIT] = run_reg;
			seq_rd_next[CMD_MODE_MSB:CMD_MODE_LSB] = mode_reg;
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg    <= ADCSQ_IDLE;
			run_reg      <= RUN_RST;
			stop_req_reg <= 1'b0;
			mode_reg     <= MODE_RST;
			seq_rd_reg   <= RDATA_RST;
		end else begin
			state_reg    <= state_next;
			run_reg      <= run_next;
			stop_req_reg <= stop_req_next;
			mode_reg     <= mode_next;
			seq_rd_reg   <= seq_rd_next;
		end
	end

	// ==========================================================
	// Sample storage
	logic [11:0] first_reg  [SLOT_COUNT];
	logic [11:0] second_reg [SLOT_COUNT];
	logic        store_en;

	// Results are taken only while a conversion sequence runs
	assign store_en = result.valid && state_reg == ADCSQ_CONV;

	// Every finished sequence overwrites its slots
	generate
		for (genvar s = 0; s < SLOT_COUNT; s++) begin : g_slot
			logic [11:0] first_next, second_next;
			always_comb begin
				first_next  = first_reg[s];
				second_next = second_reg[s];
				if (store_en && result.slot == 6'(s)) begin
					first_next  = result.first;
					second_next = DUAL ? result.second : 12'h000;
				end
			end
			always_ff @(posedge clk_sys or posedge rst) begin
				if (rst) begin
					first_reg[s]  <= 12'h000;
					second_reg[s] <= 12'h000;
				end else begin
					first_reg[s]  <= first_next;
					second_reg[s] <= second_next;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Interrupt enable, status and store read port
	logic        done_en_reg, done_en_next;
	logic        done_flag_reg, done_flag_next;
	logic        irq_reg, irq_next;
	logic [31:0] store_rd_reg, store_rd_next;
	logic        done_set;

	// Packet complete: the last slot of a sequence was written
	assign done_set = store_en && result.last;

	// Next values of enable, flag, interrupt and read data
	always_comb begin
		done_en_next   = done_en_reg;
		done_flag_next = done_flag_reg;
		store_rd_next  = RDATA_RST;
		if (store_req.write && store_req.address == STORE_IER_OFS)
			done_en_next = store_req.writedata[IRQ_DONE_BIT];
		if (store_req.write && store_req.address == STORE_ISR_OFS &&
				store_req.writedata[IRQ_DONE_BIT])
			done_flag_next = 1'b0;
		// Setting beats a same-cycle clear so no packet is missed
		if (done_set)
			done_flag_next = 1'b1;
		irq_next = done_flag_next && done_en_next;
		if (store_req.read) begin
			if (store_req.address <= STORE_SLOT_LAST) begin
				if (store_req.address < 7'(SLOT_COUNT))
					store_rd_next = slot_word(
						first_reg[store_req.address[5:0]],
						second_reg[store_req.address[5:0]]);
			end else if (store_req.address == STORE_IER_OFS)
				store_rd_next[IRQ_DONE_BIT] = done_en_reg;
			else if (store_req.address == STORE_ISR_OFS)
				store_rd_next[IRQ_DONE_BIT] = done_flag_reg;
		end
	end

	// Interrupt and read data registers
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			done_en_reg   <= DONE_EN_RST;
			done_flag_reg <= DONE_FLAG_RST;
			irq_reg       <= 1'b0;
			store_rd_reg  <= RDATA_RST;
		end else begin
			done_en_reg   <= done_en_next;
			done_flag_reg <= done_flag_next;
			irq_reg       <= irq_next;
			store_rd_reg  <= store_rd_next;
		end
	end

	// ==========================================================
	// Outputs, all straight from flip-flops
	assign seq_readdata   = seq_rd_reg;
	assign store_readdata = store_rd_reg;
	assign conv_run       = run_reg;
	assign conv_mode      = mode_reg;
	assign irq            = irq_reg;

endmodule : adcsq_csr

// ### rtl/adcsq_pkg.sv
package adcsq_pkg;

	// ==========================================================
	// Register offsets (word addresses)
	localparam logic        SEQ_CMD_OFS      = 1'h0;
	localparam logic [6:0]  STORE_SLOT_LAST  = 7'h3F;
	localparam logic [6:0]  STORE_IER_OFS    = 7'h40;
	localparam logic [6:0]  STORE_ISR_OFS    = 7'h41;

	// ==========================================================
	// Field positions
	localparam int          CMD_RUN_BIT      = 0;
	localparam int          CMD_MODE_LSB     = 1;
	localparam int          CMD_MODE_MSB     = 3;
	localparam int          IRQ_DONE_BIT     = 0;
	localparam int          FIRST_LSB        = 0;
	localparam int          SECOND_LSB       = 16;
	localparam int          SAMPLE_W         = 12;

	// ==========================================================
	// Reset values
	localparam logic        RUN_RST          = 1'h0;
	localparam logic [2:0]  MODE_RST         = 3'h0;
	localparam logic        DONE_EN_RST      = 1'h1;
	localparam logic        DONE_FLAG_RST    = 1'h0;
	localparam logic [31:0] RDATA_RST        = 32'h0;

	// ==========================================================
	// Mode codes
	localparam logic [2:0]  MODE_CONT        = 3'h0;
	localparam logic [2:0]  MODE_SINGLE      = 3'h1;
	localparam logic [2:0]  MODE_RECAL       = 3'h7;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		ADCSQ_IDLE,
		ADCSQ_CONV,
		ADCSQ_CAL
	} adcsq_state_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [6:0]  address;
		logic [31:0] writedata;
	} adcsq_req_t;

	typedef struct packed {
		logic        valid;
		logic        last;
		logic [5:0]  slot;
		logic [11:0] second;
		logic [11:0] first;
	} adcsq_result_t;

endpackage : adcsq_pkg

// ### sim/adcsq_conv_model.sv
// ==========================================================
// Converter stand-in
module adcsq_conv_model
	import adcsq_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	// Control from the block, pace from the test
	input  wire logic       conv_run,
	input  wire logic [2:0] conv_mode,
	input  wire logic       slow,
	// Results back
	output adcsq_result_t   result,
	output logic            cal_done
);
	logic       armed;
	logic [2:0] tick;
	logic [2:0] slot;
	logic [3:0] pass;
	// Eight results a packet; idle lines flip so stale data never repeats
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{armed, tick, slot, pass, cal_done} <= '0;
			result <= '0;
		end else begin
			armed <= conv_run;
			cal_done <= 1'b0;
			tick <= conv_run ? tick + 3'h1 : 3'h0;
			result <= {1'b0, ~result[30:0]};
			if (armed && conv_run && tick == (slow ? 3'h7 : 3'h1)) begin
				tick <= 3'h0;
				if (conv_mode == MODE_RECAL)
					cal_done <= 1'b1;
				else begin
					result <= {2'b10 | {1'b0, slot == 3'h7}, 3'h0, slot,
						slot, 5'h0, pass, pass, 5'h0, slot};
					slot <= slot + 3'h1;
					pass <= pass + {3'h0, slot == 3'h7};
				end
			end
		end
	end
endmodule : adcsq_conv_model

// ### sim/adcsq_csr_chk.sv
// ==========================================================
// Port checker
module adcsq_csr_chk
	import adcsq_pkg::*;
#(
	parameter int SLOT_COUNT = 64
) (
	// Clock and reset
	input wire logic          clk_sys,
	input wire logic          rst,
	// Register ports
	input wire adcsq_req_t    seq_req,
	input wire logic [31:0]   store_readdata,
	input wire adcsq_req_t    store_req,
	// Converter side and interrupt
	input wire adcsq_result_t result,
	input wire logic          cal_done,
	input wire logic          conv_run,
	input wire logic [2:0]    conv_mode,
	input wire logic          irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Command write and packet end steps
	sequence cmd_wr(b);
		seq_req.write && !seq_req.address[0] && seq_req.writedata[0] == b;
	endsequence
	sequence pkt_end;
		result.valid && result.last;
	endsequence
	run_start_a: assert property (
		cmd_wr(1) ##0 !conv_run |=> conv_run)
		else $error("run did not start");
	stop_wait_a: assert property (
		cmd_wr(0) ##0 conv_run && !cal_done && !result.valid |=> conv_run)
		else $error("early stop");
	mode_hold_a: assert property (
		conv_run && $past(conv_run) |-> $stable(conv_mode))
		else $error("mode changed while running");
	single_end_a: assert property (
		conv_run && $past(conv_run) && conv_mode == MODE_SINGLE ##0 pkt_end
		|=> !conv_run) else $error("single run did not end");
	recal_end_a: assert property (
		conv_run && $past(conv_run) && conv_mode == MODE_RECAL && cal_done
		|=> !conv_run) else $error("recalibration did not end");
	irq_cause_a: assert property (
		$rose(irq) |-> $past(result.valid && result.last) ||
		$past(store_req.write)) else $error("irq without cause");
	irq_clear_a: assert property (
		store_req.write && store_req.writedata[0] &&
		store_req.address == STORE_ISR_OFS && !result.valid |=> !irq)
		else $error("irq not cleared");
	slot_zero_a: assert property (
		store_req.read && store_req.address < SLOT_COUNT |=>
		store_readdata[31:28] == 4'h0 && store_readdata[15:12] == 4'h0)
		else $error("slot reserved bits set");
endmodule : adcsq_csr_chk
bind adcsq_csr adcsq_csr_chk #(.SLOT_COUNT(SLOT_COUNT)) u_chk (.clk_sys, .rst,
	.seq_req, .store_readdata, .store_req, .result, .cal_done, .conv_run,
	.conv_mode, .irq);

// ### sim/adcsq_csr_test.sv
module test_adcsq_csr
	import adcsq_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic          clk_sys = 1'b0;
	logic          rst = 1'b1;
	logic          slow = 1'b0;
	logic          cal_done, conv_run, irq;
	logic [2:0]    conv_mode;
	logic [31:0]   seq_readdata, store_readdata, q;
	adcsq_req_t    seq_req = '0, store_req = '0;
	adcsq_result_t result;
	int            err_total = 0, comparisons = 0, pkts = 0;
	always #2.5 clk_sys = ~clk_sys;
	adcsq_csr #(.DUAL(1'b1)) dut (.clk_sys, .rst, .seq_req, .seq_readdata,
		.store_req, .store_readdata, .result, .cal_done, .conv_run,
		.conv_mode, .irq);
	adcsq_conv_model far (.clk_sys, .rst, .conv_run, .conv_mode, .slow,
		.result, .cal_done);
	// Packets stored, for the expected slot contents
	always @(posedge clk_sys)
		if (conv_run && result.valid && result.last)
			pkts++;
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask : chk
	// One access; two cycles so a request is never redriven in one step
	task automatic bus(bit st, bit wr, logic [6:0] a, logic [31:0] d);
		adcsq_req_t r;
		r = '{read: !wr, write: wr, address: a, writedata: d};
		@(posedge clk_sys) #1;
		if (st)
			store_req = r;
		else
			seq_req = r;
		@(posedge clk_sys) #1;
		q = st ? store_readdata : seq_readdata;
		seq_req = '0;
		store_req = '0;
	endtask : bus
	task automatic wait_idle;
		int i;
		for (i = 0; i < 300 && conv_run !== 1'b0; i++) @(posedge clk_sys) #1;
		if (i == 300) begin
			chk("idle", 32'h0, conv_run);
			finish_test();
		end
	endtask : wait_idle
	task automatic slots(int p);
		for (int k = 0; k < 8; k++) begin
			bus(1, 0, 7'(k), '0);
			chk("slot", {4'h0, 3'(k), 5'h0, 4'(p), 4'h0, 4'(p), 5'h0,
				3'(k)}, q);
		end
	endtask : slots
	task automatic t_reset;
		bus(0, 0, 7'h0, '0);
		chk("cmd", 32'h0, q);
		bus(1, 0, STORE_IER_OFS, '0);
		chk("ier", 32'h1, q);
		bus(1, 0, STORE_SLOT_LAST, '0);
		chk("slot", 32'h0, q);
		bus(1, 0, STORE_ISR_OFS, '0);
		chk("isr", 32'h0, q);
		bus(1, 0, 7'h42, '0);
		chk("unmapped", 32'h0, q);
	endtask : t_reset
	task automatic t_single;
		slow = 1'b1;
		bus(0, 1, 7'h0, 32'h3);
		bus(0, 1, 7'h0, 32'hF);
		bus(0, 0, 7'h0, '0);
		chk("cmd", 32'h3, q);
		wait_idle();
		slots(pkts - 1);
		bus(1, 1, STORE_ISR_OFS, 32'h0);
		bus(1, 0, STORE_ISR_OFS, '0);
		chk("isr", 32'h1, q);
		chk("irq", 32'h1, irq);
		bus(1, 1, STORE_ISR_OFS, 32'h1);
		chk("irq", 32'h0, irq);
	endtask : t_single
	task automatic t_mask;
		bus(1, 1, STORE_IER_OFS, 32'h0);
		bus(0, 1, 7'h0, 32'h3);
		wait_idle();
		chk("irq", 32'h0, irq);
		bus(1, 0, STORE_ISR_OFS, '0);
		chk("isr", 32'h1, q);
		bus(1, 1, STORE_IER_OFS, 32'h1);
		bus(1, 0, STORE_IER_OFS, '0);
		chk("irq", 32'h1, irq);
		bus(1, 1, STORE_ISR_OFS, 32'h1);
	endtask : t_mask
	task automatic t_cont;
		int n;
		slow = 1'b0;
		bus(0, 1, 7'h0, 32'h0);
		bus(0, 1, 7'h0, 32'h1);
		n = pkts;
		for (int i = 0; i < 200 && pkts < n + 2; i++) @(posedge clk_sys) #1;
		chk("packets", 32'(n + 2), 32'(pkts));
		if (pkts < n + 2)
			finish_test();
		bus(0, 1, 7'h0, 32'h0);
		chk("run", 32'h1, conv_run);
		wait_idle();
		slots(pkts - 1);
		bus(1, 1, STORE_ISR_OFS, 32'h1);
	endtask : t_cont
	task automatic t_recal;
		bus(0, 1, 7'h0, 32'hF);
		wait_idle();
		chk("mode", 32'h7, conv_mode);
		bus(1, 0, STORE_ISR_OFS, '0);
		chk("isr", 32'h0, q);
	endtask : t_recal
	task automatic finish_test;
		$display("comparisons %0d, errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	initial begin
		repeat (3) @(posedge clk_sys);
		#1 rst = 1'b0;
		t_reset();
		t_single();
		t_mask();
		t_cont();
		t_recal();
		finish_test();
	end
endmodule : test_adcsq_csr
